// ---- design/sapsq_pkg.sv ----
// Constants for the serial-access port sequencer (host side of a video memory).
// Assumes a single 125 MHz clock; every time below is turned into whole cycles.
package sapsq_pkg;

	// ----------------------------------------------------------------
	// Clock and timing figures in nanoseconds
	// ----------------------------------------------------------------
	localparam int CLK_NS        = 8;
	localparam int T_ROW_NS      = 80;  // Row strobe low before column strobe
	localparam int T_COL_NS      = 40;  // Column strobe low before gate release
	localparam int T_GATE_NS     = 24;  // Gate high before row strobe rises
	localparam int T_PRE_NS      = 80;  // Row strobe precharge
	localparam int T_SC_HIGH_NS  = 40;  // Shift clock high phase, data settles here
	localparam int T_SC_LOW_NS   = 40;  // Shift clock low phase
	localparam int T_MSRL_NS     = 40;  // Last bit edge to split row fall
	localparam int T_RHMS_NS     = 40;  // Split row rise to next last bit edge

	// Least times round up, never below one cycle
	function automatic int cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// ----------------------------------------------------------------
	// Derived cycle counts
	// ----------------------------------------------------------------
	localparam int ROW_CYC     = cyc(T_ROW_NS);
	localparam int COL_CYC     = cyc(T_COL_NS);
	localparam int GATE_CYC    = cyc(T_GATE_NS);
	localparam int PRE_CYC     = cyc(T_PRE_NS);
	localparam int SC_HIGH_CYC = cyc(T_SC_HIGH_NS);
	localparam int SC_LOW_CYC  = cyc(T_SC_LOW_NS);
	localparam int MSRL_CYC    = cyc(T_MSRL_NS);
	localparam int RHMS_CYC    = cyc(T_RHMS_NS);

	// ----------------------------------------------------------------
	// Transfer commands and their strobe codes at the row strobe fall
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_READ_XFER  = 2'h0;
	localparam logic [1:0] OP_WRITE_XFER = 2'h1;
	localparam logic [1:0] OP_WMODE_CTRL = 2'h2;
	localparam logic [1:0] OP_SPLIT_READ = 2'h3;

	// {write_n, special_fn} per command
	localparam logic [1:0] CODE_READ_XFER  = 2'h2;
	localparam logic [1:0] CODE_WRITE_XFER = 2'h0;
	localparam logic [1:0] CODE_WMODE_CTRL = 2'h1;
	localparam logic [1:0] CODE_SPLIT_READ = 2'h3;

	// Strobe levels while idle
	localparam logic STROBE_IDLE = 1'h1;

endpackage

// ---- design/sapsq_shift_gen.sv ----
// One serial shift-clock period: high phase then low phase, from a start pulse.
// Assumes the caller waits for done before issuing the next start.
`timescale 1ns/1ps
module sapsq_shift_gen
	import sapsq_pkg::*;
#(
	parameter int HIGH_CYC = SC_HIGH_CYC,
	parameter int LOW_CYC  = SC_LOW_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	output logic      sc,
	output logic      rise,
	output logic      sample,
	output logic      done
);

	initial begin
		if (HIGH_CYC < 1 || LOW_CYC < 1 || HIGH_CYC > 255 || LOW_CYC > 255)
			$error("sapsq_shift_gen: phase counts out of range");
	end

	typedef enum logic [2:0] {
		SG_IDLE = 3'h1,
		SG_HIGH = 3'h2,
		SG_LOW  = 3'h4
	} sapsq_sg_type;

	sapsq_sg_type state_q, state_d;
	logic [7:0]   cnt_q, cnt_d;
	logic         sc_q, sc_d;

	// ----------------------------------------------------------------
	// Phase sequencing
	// ----------------------------------------------------------------
	// The edge pulse is combinational so the caller counts in the same cycle
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		sc_d    = sc_q;
		rise    = 1'b0;
		sample  = 1'b0;
		done    = 1'b0;
		case (state_q)
			SG_IDLE: begin
				if (start) begin
					sc_d    = 1'b1;
					rise    = 1'b1;
					cnt_d   = 8'(HIGH_CYC - 1);
					state_d = SG_HIGH;
				end
			end
			SG_HIGH: begin
				if (cnt_q != 8'h00) begin
					cnt_d = cnt_q - 8'h01;
				end else begin
					sample  = 1'b1;  // Data from this rise has settled
					sc_d    = 1'b0;
					cnt_d   = 8'(LOW_CYC - 1);
					state_d = SG_LOW;
				end
			end
			SG_LOW: begin
				if (cnt_q != 8'h00) begin
					cnt_d = cnt_q - 8'h01;
				end else begin
					done    = 1'b1;
					state_d = SG_IDLE;
				end
			end
			default: state_d = SG_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= SG_IDLE;
			cnt_q   <= 8'h00;
			sc_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			sc_q    <= sc_d;
		end
	end

	assign sc = sc_q;

endmodule

// ---- design/sapsq_ctrl.sv ----
// Host sequencer for the serial-access side of a dual-ported video memory.
// Assumes the memory pins are synchronous to CLK and the user side is one clock.
`timescale 1ns/1ps
module sapsq_ctrl
	import sapsq_pkg::*;
#(
	parameter int ADDR_W = 9,
	parameter int DATA_W = 4
) (
	input  wire logic              CLK,
	input  wire logic              RST,
	input  wire logic              CMD_VALID,
	output logic                   CMD_READY,
	input  wire logic [1:0]        CMD_OP,
	input  wire logic [ADDR_W-1:0] CMD_ROW,
	input  wire logic [ADDR_W-1:0] CMD_TAP,
	output logic                   CMD_REFUSED,
	input  wire logic              SER_VALID,
	output logic                   SER_READY,
	input  wire logic              SER_WRITE,
	input  wire logic [DATA_W-1:0] SER_WDATA,
	output logic                   SER_REFUSED,
	output logic                   SER_RVALID,
	output logic [DATA_W-1:0]      SER_RDATA,
	output logic                   MODE_READ,
	output logic                   MODE_WRITE,
	output logic [ADDR_W-1:0]      POINTER,
	output logic                   ROW_STROBE_N,
	output logic                   COL_STROBE_N,
	output logic                   WRITE_N,
	output logic                   SPECIAL_FN,
	output logic [ADDR_W-1:0]      ADDR,
	output logic                   TRANSFER_OUTPUT_GATE_N,
	output logic                   SERIAL_SHIFT_CLOCK,
	output logic                   SERIAL_PORT_ENABLE_N,
	input  wire logic [DATA_W-1:0] SERIAL_DATA_IO_I,
	output logic [DATA_W-1:0]      SERIAL_DATA_IO_O,
	output logic                   SERIAL_DATA_IO_OE
);

	initial begin
		if (ADDR_W < 2 || DATA_W < 1)
			$error("sapsq_ctrl: address or data width too small");
	end

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ROW  = 6'h02,
		ST_COL  = 6'h04,
		ST_GATE = 6'h08,
		ST_PRE  = 6'h10,
		ST_SER  = 6'h20
	} sapsq_st_type;

	sapsq_st_type      state_q, state_d;
	logic [7:0]        cnt_q, cnt_d;
	logic [7:0]        msrl_q, msrl_d;
	logic [7:0]        rhms_q, rhms_d;
	logic [1:0]        op_q, op_d;
	logic [ADDR_W-1:0] tap_q, tap_d;
	logic [ADDR_W-1:0] ptr_q, ptr_d;
	logic              rd_ok_q, rd_ok_d;
	logic              wr_ok_q, wr_ok_d;
	logic              init_q, init_d;
	logic              half_done_q, half_done_d;
	logic              sc_seen_q, sc_seen_d;
	logic              wr_q, wr_d;
	logic              ras_q, ras_d;
	logic              cas_q, cas_d;
	logic              gate_q, gate_d;
	logic [1:0]        code_q, code_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] sdo_q, sdo_d;
	logic              oe_q, oe_d;
	logic              se_q, se_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic              rvalid_q, rvalid_d;
	logic              sg_start;
	logic              sg_sc;
	logic              sg_rise;
	logic              sg_sample;
	logic              sg_done;
	logic              at_half_end;
	logic              split_ready;
	logic [1:0]        code_sel;

	// ----------------------------------------------------------------
	// Shift clock generator
	// ----------------------------------------------------------------
	sapsq_shift_gen #(
		.HIGH_CYC (SC_HIGH_CYC),
		.LOW_CYC  (SC_LOW_CYC)
	) u_shift (
		.clk    (CLK),
		.rst    (RST),
		.start  (sg_start),
		.sc     (sg_sc),
		.rise   (sg_rise),
		.sample (sg_sample),
		.done   (sg_done)
	);

	// Pointer sits on the last word of either half
	assign at_half_end = &ptr_q[ADDR_W-2:0];
	// Inactive half may be reloaded only once the active half is spent
	assign split_ready = half_done_q && (msrl_q == 8'h00) && sc_seen_q;

	// Strobe code for each transfer
	always_comb begin
		case (CMD_OP)
			OP_READ_XFER:  code_sel = CODE_READ_XFER;
			OP_WRITE_XFER: code_sel = CODE_WRITE_XFER;
			OP_WMODE_CTRL: code_sel = CODE_WMODE_CTRL;
			default:       code_sel = CODE_SPLIT_READ;
		endcase
	end

	// ----------------------------------------------------------------
	// Main sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d     = state_q;
		cnt_d       = cnt_q;
		msrl_d      = (msrl_q != 8'h00) ? msrl_q - 8'h01 : msrl_q;
		rhms_d      = (rhms_q != 8'h00) ? rhms_q - 8'h01 : rhms_q;
		op_d        = op_q;
		tap_d       = tap_q;
		ptr_d       = ptr_q;
		rd_ok_d     = rd_ok_q;
		wr_ok_d     = wr_ok_q;
		init_d      = init_q;
		half_done_d = half_done_q;
		sc_seen_d   = sc_seen_q;
		wr_d        = wr_q;
		ras_d       = ras_q;
		cas_d       = cas_q;
		gate_d      = gate_q;
		code_d      = code_q;
		addr_d      = addr_q;
		sdo_d       = sdo_q;
		oe_d        = oe_q;
		se_d        = se_q;
		rdata_d     = rdata_q;
		rvalid_d    = 1'b0;
		sg_start    = 1'b0;
		CMD_READY   = 1'b0;
		CMD_REFUSED = 1'b0;
		SER_READY   = 1'b0;
		SER_REFUSED = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (CMD_VALID) begin
					if (CMD_OP == OP_SPLIT_READ && !init_q) begin
						CMD_READY   = 1'b1;
						CMD_REFUSED = 1'b1;
					end else if (CMD_OP != OP_SPLIT_READ || split_ready) begin
						CMD_READY = 1'b1;
						op_d      = CMD_OP;
						tap_d     = CMD_TAP;
						ras_d     = 1'b0;
						gate_d    = 1'b0;
						code_d    = code_sel;
						addr_d    = CMD_ROW;
						cnt_d     = 8'(ROW_CYC - 1);
						state_d   = ST_ROW;
					end
				end else if (SER_VALID) begin
					if (SER_WRITE ? !wr_ok_q : !rd_ok_q) begin
						SER_READY   = 1'b1;
						SER_REFUSED = 1'b1;
					end else if (!(at_half_end && rhms_q != 8'h00)) begin
						SER_READY = 1'b1;
						wr_d      = SER_WRITE;
						sdo_d     = SER_WDATA;
						oe_d      = SER_WRITE;
						se_d      = 1'b0;
						sg_start  = 1'b1;
						ptr_d     = ptr_q + 1'b1;
						sc_seen_d = 1'b1;
						if (at_half_end) begin
							half_done_d = 1'b1;
							msrl_d      = 8'(MSRL_CYC);
						end
						state_d = ST_SER;
					end
				end
			end
			ST_ROW: begin
				if (cnt_q != 8'h00) begin
					cnt_d = cnt_q - 8'h01;
				end else begin
					cas_d   = 1'b0;
					addr_d  = tap_q;
					cnt_d   = 8'(COL_CYC - 1);
					state_d = ST_COL;
				end
			end
			ST_COL: begin
				if (cnt_q != 8'h00) begin
					cnt_d = cnt_q - 8'h01;
				end else begin
					gate_d  = 1'b1;
					cnt_d   = 8'(GATE_CYC - 1);
					state_d = ST_GATE;
				end
			end
			ST_GATE: begin
				if (cnt_q != 8'h00) begin
					cnt_d = cnt_q - 8'h01;
				end else begin
					ras_d   = STROBE_IDLE;
					cas_d   = STROBE_IDLE;
					code_d  = CODE_READ_XFER;
					cnt_d   = 8'(PRE_CYC - 1);
					state_d = ST_PRE;
					if (op_q == OP_READ_XFER || op_q == OP_SPLIT_READ) begin
						rd_ok_d = 1'b1;
						wr_ok_d = 1'b0;
					end else begin
						rd_ok_d = 1'b0;
						wr_ok_d = 1'b1;
					end
					if (op_q == OP_SPLIT_READ) begin
						half_done_d = 1'b0;
						sc_seen_d   = 1'b0;
						rhms_d      = 8'(RHMS_CYC);
					end else begin
						ptr_d       = tap_q;
						half_done_d = 1'b0;
					end
					if (op_q == OP_READ_XFER)
						init_d = 1'b1;
				end
			end
			ST_PRE: begin
				if (cnt_q != 8'h00)
					cnt_d = cnt_q - 8'h01;
				else
					state_d = ST_IDLE;
			end
			ST_SER: begin
				// Read data is valid only after the rise that presents it
				if (sg_sample && !wr_q) begin
					rdata_d  = SERIAL_DATA_IO_I;
					rvalid_d = 1'b1;
				end
				if (sg_done) begin
					oe_d    = 1'b0;
					se_d    = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q     <= ST_IDLE;
			cnt_q       <= 8'h00;
			msrl_q      <= 8'h00;
			rhms_q      <= 8'h00;
			op_q        <= 2'h0;
			tap_q       <= '0;
			ptr_q       <= '0;
			rd_ok_q     <= 1'b0;
			wr_ok_q     <= 1'b0;
			init_q      <= 1'b0;
			half_done_q <= 1'b0;
			sc_seen_q   <= 1'b0;
			wr_q        <= 1'b0;
			ras_q       <= 1'b1;
			cas_q       <= 1'b1;
			gate_q      <= 1'b1;
			code_q      <= CODE_READ_XFER;  // Idle code, no write request
			addr_q      <= '0;
			sdo_q       <= '0;
			oe_q        <= 1'b0;
			se_q        <= 1'b1;
			rdata_q     <= '0;
			rvalid_q    <= 1'b0;
		end else begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			msrl_q      <= msrl_d;
			rhms_q      <= rhms_d;
			op_q        <= op_d;
			tap_q       <= tap_d;
			ptr_q       <= ptr_d;
			rd_ok_q     <= rd_ok_d;
			wr_ok_q     <= wr_ok_d;
			init_q      <= init_d;
			half_done_q <= half_done_d;
			sc_seen_q   <= sc_seen_d;
			wr_q        <= wr_d;
			ras_q       <= ras_d;
			cas_q       <= cas_d;
			gate_q      <= gate_d;
			code_q      <= code_d;
			addr_q      <= addr_d;
			sdo_q       <= sdo_d;
			oe_q        <= oe_d;
			se_q        <= se_d;
			rdata_q     <= rdata_d;
			rvalid_q    <= rvalid_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin and status outputs
	// ----------------------------------------------------------------
	assign ROW_STROBE_N           = ras_q;
	assign COL_STROBE_N           = cas_q;
	assign WRITE_N                = code_q[1];
	assign SPECIAL_FN             = code_q[0];
	assign ADDR                   = addr_q;
	assign TRANSFER_OUTPUT_GATE_N = gate_q;
	assign SERIAL_SHIFT_CLOCK     = sg_sc;
	assign SERIAL_PORT_ENABLE_N   = se_q;
	assign SERIAL_DATA_IO_O       = sdo_q;
	assign SERIAL_DATA_IO_OE      = oe_q;
	assign SER_RDATA              = rdata_q;
	assign SER_RVALID             = rvalid_q;
	assign MODE_READ              = rd_ok_q;
	assign MODE_WRITE             = wr_ok_q;
	assign POINTER                = ptr_q;

endmodule

// ---- tb/sapsq_ctrl_sva.sv ----
// Checker for the serial-port sequencer: modes, strobe order, shift pacing.
// Assumes it is bound to sapsq_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module sapsq_ctrl_sva
	import sapsq_pkg::*;
#(
	parameter int ADDR_W = 9
) (
	input wire logic              CLK,
	input wire logic              RST,
	input wire logic              CMD_READY,
	input wire logic [1:0]        CMD_OP,
	input wire logic              CMD_REFUSED,
	input wire logic              SER_READY,
	input wire logic              SER_WRITE,
	input wire logic              SER_REFUSED,
	input wire logic              MODE_READ,
	input wire logic              MODE_WRITE,
	input wire logic [ADDR_W-1:0] POINTER,
	input wire logic              ROW_STROBE_N,
	input wire logic              WRITE_N,
	input wire logic              SPECIAL_FN,
	input wire logic              TRANSFER_OUTPUT_GATE_N,
	input wire logic              SERIAL_SHIFT_CLOCK,
	input wire logic              SERIAL_PORT_ENABLE_N
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic [7:0] sc_age_q;
	logic       split_pend_q;
	logic       rd_seen_q;

	// ----
	// Helpers
	// ----
	// Age saturates so a long idle never wraps back to a small value
	always_ff @(posedge CLK) begin
		if (RST) begin
			sc_age_q     <= 8'hff;
			split_pend_q <= 1'b0;
			rd_seen_q    <= 1'b0;
		end else begin
			if ($rose(SERIAL_SHIFT_CLOCK)) sc_age_q <= 8'h1;
			else if (sc_age_q != 8'hff) sc_age_q <= sc_age_q + 8'h1;
			if ($fell(ROW_STROBE_N) && WRITE_N && SPECIAL_FN) split_pend_q <= 1'b1;
			else if ($rose(SERIAL_SHIFT_CLOCK)) split_pend_q <= 1'b0;
			if ($fell(ROW_STROBE_N) && WRITE_N && !SPECIAL_FN) rd_seen_q <= 1'b1;
		end
	end

	// ----
	// Properties
	// ----
	property p_split_order;
		CMD_READY && CMD_OP == OP_SPLIT_READ |-> CMD_REFUSED == !rd_seen_q;
	endproperty
	a_split_order: assert property (p_split_order) else $error("split refusal wrong");
	property p_wr_mode;
		SER_READY && SER_WRITE |-> SER_REFUSED == !MODE_WRITE;
	endproperty
	a_wr_mode: assert property (p_wr_mode) else $error("write refusal wrong");
	property p_rd_mode;
		SER_READY && !SER_WRITE |-> SER_REFUSED == !MODE_READ;
	endproperty
	a_rd_mode: assert property (p_rd_mode) else $error("read refusal wrong");
	property p_leave_write;
		$fell(MODE_WRITE) |-> $rose(ROW_STROBE_N) && $past(WRITE_N);
	endproperty
	a_leave_write: assert property (p_leave_write) else $error("write mode left");
	property p_enter_write;
		$rose(MODE_WRITE) |-> $rose(ROW_STROBE_N) && !$past(WRITE_N);
	endproperty
	a_enter_write: assert property (p_enter_write) else $error("write mode entered");
	property p_gate;
		!TRANSFER_OUTPUT_GATE_N |-> !ROW_STROBE_N;
	endproperty
	a_gate: assert property (p_gate) else $error("gate low outside transfer");
	property p_step;
		$rose(SERIAL_SHIFT_CLOCK) |-> !SERIAL_PORT_ENABLE_N && POINTER == $past(POINTER) + 1'b1;
	endproperty
	a_step: assert property (p_step) else $error("pointer step wrong");
	property p_split_space;
		$fell(ROW_STROBE_N) && WRITE_N && SPECIAL_FN |-> sc_age_q >= MSRL_CYC && !split_pend_q;
	endproperty
	a_split_space: assert property (p_split_space) else $error("split too early");
endmodule
bind sapsq_ctrl sapsq_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (
	.CLK, .RST, .CMD_READY, .CMD_OP, .CMD_REFUSED, .SER_READY, .SER_WRITE, .SER_REFUSED,
	.MODE_READ, .MODE_WRITE, .POINTER, .ROW_STROBE_N, .WRITE_N, .SPECIAL_FN,
	.TRANSFER_OUTPUT_GATE_N, .SERIAL_SHIFT_CLOCK, .SERIAL_PORT_ENABLE_N
);

// ---- tb/sapsq_vram_model.sv ----
// Behavioural memory serial side: modes, tap pointer and serial register.
// Assumes the bench resolves the data bus and the strobes come from one clock.
`timescale 1ns/1ps
module sapsq_vram_model
	import sapsq_pkg::*;
#(
	parameter int MSRL_NS = T_MSRL_NS,
	parameter int RHMS_NS = T_RHMS_NS
) (
	input  wire logic       row_n,
	input  wire logic       col_n,
	input  wire logic       wr_n,
	input  wire logic       sfn,
	input  wire logic [8:0] addr,
	input  wire logic       gate_n,
	input  wire logic       sclk,
	input  wire logic       se_n,
	input  wire logic [3:0] dq,
	output logic      [3:0] dq_o,
	output int              faults
);
	logic [3:0] serial_register_port [512];
	logic [8:0] ptr     = 9'h0;
	logic [8:0] tap, row;
	logic [1:0] code;
	logic       xfer    = 1'b0;
	logic       rmode   = 1'b0;
	logic       wmode   = 1'b0;
	logic       inited  = 1'b0;
	logic       shifted = 1'b1;
	realtime    t_sc    = -1.0e3;
	realtime    t_rr    = -1.0e3;
	// Released bus starts at a defined level
	initial begin
		faults = 0;
		dq_o = 4'h0;
	end
	// Gate low at row fall marks a transfer; later edges use the latched code
	always @(negedge row_n) begin
		#1;
		xfer = !gate_n;
		code = {wr_n, sfn};
		row = addr;
		if (xfer && code == CODE_SPLIT_READ) begin
			if (!inited || !shifted) faults++;
			if ($realtime - t_sc < MSRL_NS) faults++;
			shifted = 1'b0;
		end
	end
	// Tap rides on the address at the column fall
	always @(negedge col_n) begin
		#1;
		tap = addr;
	end
	// Row rise settles mode and pointer; split keeps the pointer
	always @(posedge row_n) begin
		if (xfer && code[1]) begin
			rmode = 1'b1;
			wmode = 1'b0;
			t_rr = $realtime;
			if (code == CODE_READ_XFER) begin
				inited = 1'b1;
				shifted = 1'b1;
				ptr = tap;
				for (int i = 0; i < 512; i++) serial_register_port[i] = row[3:0] + 4'(i);
			end
		end else if (xfer) begin
			rmode = 1'b0;
			wmode = 1'b1;
			ptr = tap;
		end
		xfer = 1'b0;
	end
	// One word per enabled shift rise
	always @(posedge sclk) begin
		#1;
		if (!se_n) begin
			if (ptr[7:0] == 8'hff && $realtime - t_rr < RHMS_NS) faults++;
			if (wmode) serial_register_port[ptr] = dq;
			else if (rmode) dq_o = serial_register_port[ptr];
			ptr = ptr + 9'h1;
			shifted = 1'b1;
			t_sc = $realtime;
		end
	end
	// Released bus shows the inverse, never a stale copy
	always @(posedge se_n) dq_o = ~dq_o;
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench: sequencer against the memory model.
// Assumes one 125 MHz clock; the bench resolves the shared data bus.
`timescale 1ns/1ps
module testbench;
	import sapsq_pkg::*;
	logic       clk, rst, cmd_valid, ser_valid, ser_write, cmd_rdy, cmd_ref, ser_rdy, ser_ref;
	logic       rvalid, mode_r, mode_w, row_n, col_n, wr_n, sfn, gate_n, sclk, se_n, dq_oe;
	logic [1:0] cmd_op, r;
	logic [8:0] cmd_row, cmd_tap, ptr, addr;
	logic [3:0] ser_wdata, d, rdata, dq_o, mdq, dq;
	int         mismatches, samples_checked, faults;
	assign dq = dq_oe ? dq_o : mdq;
	sapsq_ctrl dut (
		.CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_rdy), .CMD_OP(cmd_op),
		.CMD_ROW(cmd_row), .CMD_TAP(cmd_tap), .CMD_REFUSED(cmd_ref), .SER_VALID(ser_valid),
		.SER_READY(ser_rdy), .SER_WRITE(ser_write), .SER_WDATA(ser_wdata), .SER_REFUSED(ser_ref),
		.SER_RVALID(rvalid), .SER_RDATA(rdata), .MODE_READ(mode_r), .MODE_WRITE(mode_w),
		.POINTER(ptr), .ROW_STROBE_N(row_n), .COL_STROBE_N(col_n), .WRITE_N(wr_n),
		.SPECIAL_FN(sfn), .ADDR(addr), .TRANSFER_OUTPUT_GATE_N(gate_n),
		.SERIAL_SHIFT_CLOCK(sclk), .SERIAL_PORT_ENABLE_N(se_n), .SERIAL_DATA_IO_I(dq),
		.SERIAL_DATA_IO_O(dq_o), .SERIAL_DATA_IO_OE(dq_oe)
	);
	sapsq_vram_model u_mem (
		.row_n(row_n), .col_n(col_n), .wr_n(wr_n), .sfn(sfn), .addr(addr), .gate_n(gate_n),
		.sclk(sclk), .se_n(se_n), .dq(dq), .dq_o(mdq), .faults(faults)
	);
	// ----
	// Shared tasks
	// ----
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Valid is held until ready is seen before an edge or lim negedges pass, then dropped after the next edge
	task automatic req(input logic c, input int lim, output logic [1:0] rr);
		rr = 2'b00;
		@(posedge clk);
		#1;
		if (c) cmd_valid = 1'b1;
		else ser_valid = 1'b1;
		for (int n = 0; n < lim; n++) begin
			@(negedge clk);
			if ((c ? cmd_rdy : ser_rdy) === 1'b1) begin
				rr = {1'b1, c ? cmd_ref : ser_ref};
				break;
			end
		end
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		ser_valid = 1'b0;
	endtask
	task automatic cmd(input logic [1:0] op, input logic [8:0] row, input logic [8:0] tap,
		input int lim);
		cmd_op = op;
		cmd_row = row;
		cmd_tap = tap;
		req(1'b1, lim, r);
		if (r == 2'b10) begin
			repeat (ROW_CYC + COL_CYC + GATE_CYC + PRE_CYC) @(posedge clk);
			#1;
		end
	endtask
	task automatic ser(input logic w, input logic [3:0] wd);
		ser_write = w;
		ser_wdata = wd;
		d = 4'hx;
		req(1'b0, 200, r);
		for (int n = 0; n < 20 && !w && r == 2'b10; n++) begin
			@(negedge clk);
			if (rvalid === 1'b1) begin
				d = rdata;
				break;
			end
		end
		// Next stimulus starts just after an edge, like every other drive
		@(posedge clk);
		#1;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_refuse;
		cmd(OP_SPLIT_READ, 9'h7, 9'h0, 200);
		check(r, 2'b11);
		ser(1'b0, 4'h0);
		check(r, 2'b11);
		ser(1'b1, 4'h5);
		check(r, 2'b11);
	endtask
	// Reads wrap the pointer across the top of the register
	task automatic t_read;
		cmd(OP_READ_XFER, 9'h5, 9'h1fe, 200);
		check({r, mode_r, mode_w, ptr}, {4'b1010, 9'h1fe});
		for (int i = 0; i < 3; i++) begin
			ser(1'b0, 4'h0);
			check({r, d}, {2'b10, 4'h5 + 4'(9'h1fe + i)});
		end
		check(ptr, 9'h001);
		ser(1'b1, 4'h9);
		check(r, 2'b11);
	endtask
	// Second split with no shift between must stall
	task automatic t_split;
		cmd(OP_SPLIT_READ, 9'h7, 9'h0, 200);
		check({r, mode_r, ptr}, {3'b101, 9'h001});
		cmd(OP_SPLIT_READ, 9'h8, 9'h0, 40);
		check(r, 2'b00);
		ser(1'b0, 4'h0);
		check({r, d}, 6'h26);
	endtask
	task automatic t_write;
		cmd(OP_WMODE_CTRL, 9'h10, 9'h0ff, 200);
		check({r, mode_r, mode_w, ptr}, {4'b1001, 9'h0ff});
		ser(1'b0, 4'h0);
		check(r, 2'b11);
		ser(1'b1, 4'ha);
		ser(1'b1, 4'h3);
		repeat (12) @(posedge clk);
		#1;
		check({r, u_mem.serial_register_port[9'h0ff], u_mem.serial_register_port[9'h100]}, 10'h2a3);
		cmd(OP_WRITE_XFER, 9'h20, 9'h040, 200);
		check({r, mode_r, mode_w, ptr}, {4'b1001, 9'h040});
		cmd(OP_READ_XFER, 9'h3, 9'h0, 200);
		check({r, mode_r, mode_w}, 4'b1010);
		ser(1'b0, 4'h0);
		check({r, d}, 6'h23);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Whole run is near 300 cycles; the limit of 12500 cycles leaves ample margin
	initial begin
		#100000;
		mismatches++;
		end_of_test();
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		ser_valid = 1'b0;
		ser_write = 1'b0;
		cmd_op = 2'h0;
		cmd_row = 9'h0;
		cmd_tap = 9'h0;
		ser_wdata = 4'h0;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		check({row_n, wr_n, sfn, gate_n, sclk, se_n, dq_oe, mode_r, mode_w, ptr}, 18'h35000);
		t_refuse();
		t_read();
		t_split();
		t_write();
		check(24'(faults), 24'h0);
		end_of_test();
	end
endmodule
